// [common/uep_pkg.sv]
// constants and carrier types for the eprom programming and read controller
package uep_pkg;

    // ----------------------------------------------------------------
    // array shape
    // ----------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int WORDS = 512;
    localparam int CNT_W = 20;
    localparam int NPLS_W = 5;

    // ----------------------------------------------------------------
    // timing, figures in their own units, then cycles at clk_sys
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_ACC_NS = 575;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    localparam int T_SETUP_US = 10;
    localparam int SETUP_CYC = T_SETUP_US * CLK_MHZ;
    localparam int T_HOLD_US = 10;
    localparam int HOLD_CYC = T_HOLD_US * CLK_MHZ;
    localparam int T_GAP_US = 500;
    localparam int GAP_CYC_DEF = T_GAP_US * CLK_MHZ;
    localparam int T_PULSE_MS = 3;
    localparam int T_PULSE_MAX_MS = 5;
    localparam int PULSE_CYC_DEF = T_PULSE_MS * 1000 * CLK_MHZ;
    localparam int T_ENERGY_MS = 60;
    localparam int PULSE_NUM = (T_ENERGY_MS + T_PULSE_MS - 1) / T_PULSE_MS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [CNT_W-1:0] uep_cnt_t;
    typedef logic [NPLS_W-1:0] uep_npls_t;

    typedef enum logic {
        UEP_OP_READ,
        UEP_OP_PROG
    } uep_op_t;

    typedef struct packed {
        uep_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } uep_req_t;

    // everything the controller drives toward the memory
    typedef struct packed {
        logic sel_b;
        logic rw;
        logic program_pulse_input;
        logic [ADDR_W-1:0] word_index_inputs;
        logic [DATA_W-1:0] word_bit_lines;
        logic word_bit_lines_oe_b;
    } uep_pins_t;

endpackage

// [hw/uep_ctrl.sv]
// host-side controller that reads and programs a 512 x 8 uv-erasable prom
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module uep_ctrl
    import uep_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_CYC_DEF,
    parameter int GAP_CYC = GAP_CYC_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // user request
    input wire logic req_valid,
    input wire uep_req_t req,
    output logic req_ready,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // memory pins
    output uep_pins_t pins,
    input wire logic [DATA_W-1:0] word_bit_lines_in
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACC,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_GAP,
        ST_WR_HOLD,
        ST_WR_RECOVER
    } uep_state_t;

    uep_state_t st_q, st_d;
    uep_cnt_t cnt_q, cnt_d;
    uep_npls_t npls_q, npls_d;
    uep_pins_t pins_q, pins_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic done_q, done_d;
    logic [DATA_W-1:0] din_s1_q, din_s2_q;

    // bus let go: deselected, read level, no pulse, drivers off
    function automatic uep_pins_t uep_released(input uep_pins_t p);
        uep_pins_t r;
        r = p;
        r.sel_b = 1'b1;
        r.rw = 1'b1;
        r.program_pulse_input = 1'b0;
        r.word_bit_lines_oe_b = 1'b1;
        return r;
    endfunction

    function automatic logic uep_hit(input uep_cnt_t c, input int n);
        return c == uep_cnt_t'(n - 1);
    endfunction

    // ----------------------------------------------------------------
    // data pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            din_s1_q <= word_bit_lines_in;
            din_s2_q <= din_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + uep_cnt_t'(1);
        npls_d = npls_q;
        pins_d = pins_q;
        rdata_d = rdata_q;
        done_d = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                cnt_d = '0;
                pins_d = uep_released(pins_q);
                if (req_valid) begin
                    pins_d.sel_b = 1'b0;
                    pins_d.word_index_inputs = req.addr;
                    if (req.op == UEP_OP_READ) begin
                        pins_d.rw = 1'b1;
                        st_d = ST_RD_ACC;
                    end else begin
                        // whole word driven in parallel before any pulse
                        pins_d.rw = 1'b0;
                        pins_d.word_bit_lines = req.data;
                        pins_d.word_bit_lines_oe_b = 1'b0;
                        npls_d = '0;
                        st_d = ST_WR_SETUP;
                    end
                end
            end
            ST_RD_ACC: begin
                // wait the access time plus the synchroniser depth
                if (uep_hit(cnt_q, ACC_CYC + SYNC_CYC)) begin
                    rdata_d = din_s2_q;
                    done_d = 1'b1;
                    pins_d = uep_released(pins_q);
                    st_d = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                if (uep_hit(cnt_q, SETUP_CYC)) begin
                    pins_d.program_pulse_input = 1'b1;
                    cnt_d = '0;
                    st_d = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE: begin
                if (uep_hit(cnt_q, PULSE_CYC)) begin
                    pins_d.program_pulse_input = 1'b0;
                    npls_d = npls_q + uep_npls_t'(1);
                    cnt_d = '0;
                    if (npls_q == uep_npls_t'(PULSE_NUM - 1)) begin
                        st_d = ST_WR_HOLD;
                    end else begin
                        st_d = ST_WR_GAP;
                    end
                end
            end
            ST_WR_GAP: begin
                // recovery gap; select, address and data stay put
                if (uep_hit(cnt_q, GAP_CYC)) begin
                    pins_d.program_pulse_input = 1'b1;
                    cnt_d = '0;
                    st_d = ST_WR_PULSE;
                end
            end
            ST_WR_HOLD: begin
                if (uep_hit(cnt_q, HOLD_CYC)) begin
                    pins_d = uep_released(pins_q);
                    cnt_d = '0;
                    st_d = ST_WR_RECOVER;
                end
            end
            ST_WR_RECOVER: begin
                // read setup after programming before next access
                if (uep_hit(cnt_q, SETUP_CYC)) begin
                    done_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            npls_q <= '0;
            pins_q <= '{sel_b: 1'b1, rw: 1'b1, program_pulse_input: 1'b0,
                        word_index_inputs: 9'h000, word_bit_lines: 8'h00,
                        word_bit_lines_oe_b: 1'b1};
            rdata_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            npls_q <= npls_d;
            pins_q <= pins_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
        end
    end

    assign req_ready = (st_q == ST_IDLE);
    assign done = done_q;
    assign rdata = rdata_q;
    assign pins = pins_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    uep_cnt_t plen_q;
    uep_cnt_t stab_q;
    logic wr_set;

    assign wr_set = !pins_q.sel_b && !pins_q.rw && !pins_q.word_bit_lines_oe_b;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            plen_q <= '0;
            stab_q <= '0;
        end else begin
            plen_q <= pins_q.program_pulse_input ? plen_q + uep_cnt_t'(1) : '0;
            stab_q <= wr_set ? stab_q + uep_cnt_t'(1) : '0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence prog_edge;
        $rose(pins_q.program_pulse_input);
    endsequence

    sequence prog_stays_high;
        pins_q.program_pulse_input [*8];
    endsequence

    property held_through_pulse;
        pins_q.program_pulse_input && $past(pins_q.program_pulse_input) |->
            $stable(pins_q.sel_b) && $stable(pins_q.word_index_inputs)
            && $stable(pins_q.word_bit_lines);
    endproperty

    pulse_selected_a: assert property (
        pins_q.program_pulse_input |-> wr_set)
        else $error("program pulse without select, write level and data drive");

    pulse_min_len_a: assert property (
        prog_edge |-> prog_stays_high)
        else $error("program pulse shorter than eight cycles");

    pulse_width_a: assert property (
        $fell(pins_q.program_pulse_input) |-> plen_q == uep_cnt_t'(PULSE_CYC))
        else $error("program pulse width differs from the configured width");

    pulse_total_a: assert property (
        (st_q == ST_WR_HOLD) && ($past(st_q) != ST_WR_HOLD) |->
            npls_q == uep_npls_t'(PULSE_NUM))
        else $error("programming ended with wrong pulse count");

    setup_time_a: assert property (
        $rose(pins_q.program_pulse_input) && ($past(st_q) == ST_WR_SETUP) |->
            stab_q >= uep_cnt_t'(SETUP_CYC))
        else $error("first pulse started before setup time elapsed");

    read_no_pulse_a: assert property (
        pins_q.rw |-> !pins_q.program_pulse_input)
        else $error("program pulse during read level");

    stable_pulse_a: assert property (held_through_pulse)
        else $error("select, address or data moved during a pulse");

    gap_after_pulse_a: assert property (
        $fell(pins_q.program_pulse_input) |-> !pins_q.program_pulse_input [*8])
        else $error("no recovery gap after a program pulse");

endmodule

// [verification/tb_top.sv]
// self-checking bench for the prom read and program controller
module tb_top
    import uep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PCYC = 40;
    localparam int GCYC = 20;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    uep_req_t req = '0;
    logic req_ready, done, mem_drv;
    logic [DATA_W-1:0] rdata, mem_out, wire_v;
    logic [DATA_W-1:0] last_v = 8'h00;
    uep_pins_t pins;
    int failures = 0;
    int compares = 0;
    int npls = 0;
    int wcnt = 0;
    logic [3:0] ctl_v;

    always #4 clk_sys = ~clk_sys;

    uep_ctrl #(.PULSE_CYC(PCYC), .GAP_CYC(GCYC)) uep_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .rdata(rdata),
        .pins(pins), .word_bit_lines_in(wire_v));
    uep_mem_model uep_mem_model_i (.sel_b(pins.sel_b), .rw(pins.rw),
        .program_pulse_input(pins.program_pulse_input), .word_index_inputs(pins.word_index_inputs),
        .word_bit_lines_in(wire_v), .word_bit_lines_out(mem_out), .drive(mem_drv));

    // ----
    // shared wire: no pull, so a released bus wanders
    // ----
    assign wire_v = !pins.word_bit_lines_oe_b ? pins.word_bit_lines : mem_drv ? mem_out : ~last_v;
    always @(posedge clk_sys) last_v <= wire_v;
    assign ctl_v = {pins.sel_b, pins.rw, pins.word_bit_lines_oe_b, pins.program_pulse_input};

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("counts: compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // pulse width and pin state seen on every program pulse
    // sampled mid-cycle, away from the edge that moves the pins
    always @(negedge clk_sys) begin
        if (pins.program_pulse_input === 1'b1) begin
            wcnt++;
            if (wcnt == 1) check(20'(ctl_v[3:1]), 20'h0);
        end else if (wcnt != 0) begin
            check(20'(wcnt), 20'(PCYC));
            npls++;
            wcnt = 0;
        end
    end

    // ----
    // request driver, lim 0 returns right after the take
    // ----
    task automatic do_op(input uep_op_t op, input logic [8:0] a, input logic [7:0] d,
        input int lim);
        int i;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, data: d};
        for (i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        if (i == 20) begin
            failures++;
            wrap_up();
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (i = 0; i < lim; i++) begin
            @(negedge clk_sys);
            if (done === 1'b1) break;
        end
        if (lim != 0 && i == lim) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic t_idle();
        check(20'(ctl_v), 20'hE);
        do_op(UEP_OP_READ, 9'h000, 8'h00, 200);
        check(20'(rdata), 20'h00);
        check(20'(npls), 20'h0);
        $display("test idle done");
    endtask

    task automatic t_prog();
        npls = 0;
        do_op(UEP_OP_PROG, 9'h1FF, 8'hA5, 6000);
        check(20'(npls), 20'h14);
        do_op(UEP_OP_READ, 9'h1FF, 8'h00, 200);
        check(20'(rdata), 20'hA5);
        do_op(UEP_OP_READ, 9'h1FE, 8'h00, 200);
        check(20'(rdata), 20'h00);
        do_op(UEP_OP_READ, 9'h0FF, 8'h00, 200);
        check(20'(rdata), 20'h00);
        $display("test program done");
    endtask

    task automatic t_or();
        do_op(UEP_OP_PROG, 9'h1FF, 8'h0F, 6000);
        do_op(UEP_OP_READ, 9'h1FF, 8'h00, 200);
        check(20'(rdata), 20'hAF);
        do_op(UEP_OP_PROG, 9'h000, 8'h5A, 6000);
        do_op(UEP_OP_READ, 9'h000, 8'h00, 200);
        check(20'(rdata), 20'h5A);
        $display("test or done");
    endtask

    task automatic t_reset();
        npls = 0;
        do_op(UEP_OP_PROG, 9'h055, 8'hFF, 0);
        @(negedge clk_sys);
        // busy in setup: selected, write level, data driven, no pulse yet
        check(20'(req_ready), 20'h0);
        check(20'(ctl_v), 20'h0);
        check(20'(pins.word_index_inputs), 20'h055);
        check(20'(pins.word_bit_lines), 20'h0FF);
        repeat (100) @(posedge clk_sys);
        rst_b <= 1'b0;
        @(negedge clk_sys);
        check(20'(ctl_v), 20'hE);
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        do_op(UEP_OP_READ, 9'h055, 8'h00, 200);
        check(20'(rdata), 20'h00);
        check(20'(npls), 20'h0);
        $display("test reset done");
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_idle();
        t_prog();
        t_or();
        t_reset();
        wrap_up();
    end
endmodule

// [verification/uep_mem_model.sv]
// behavioural model of the 512 x 8 uv-erasable prom on the pins
module uep_mem_model
    import uep_pkg::*;
#(
    parameter realtime ACC_NS = 575.0
) (
    // control
    input wire logic sel_b,
    input wire logic rw,
    input wire logic program_pulse_input,
    // address and data
    input wire logic [ADDR_W-1:0] word_index_inputs,
    input wire logic [DATA_W-1:0] word_bit_lines_in,
    output logic [DATA_W-1:0] word_bit_lines_out,
    output logic drive
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] mem [WORDS];
    logic valid;
    int tok;

    initial begin
        for (int i = 0; i < WORDS; i++) mem[i] = 8'h00;
        valid = 1'b0;
        tok = 0;
    end

    // a change restarts the access time; the inverted word shows until it runs out
    always @(word_index_inputs, sel_b, rw) begin
        tok++;
        valid = 1'b0;
        fork
            begin
                automatic int my = tok;
                #(ACC_NS);
                if (my == tok) valid = 1'b1;
            end
        join_none
    end

    // programming can only set bits
    always @(posedge program_pulse_input) begin
        if (!sel_b && !rw) begin
            mem[word_index_inputs] |= word_bit_lines_in;
        end
    end

    assign drive = !sel_b && rw;
    assign word_bit_lines_out = valid ? mem[word_index_inputs] : ~mem[word_index_inputs];
endmodule
